// ---- pkg/rccdc_cfg.svh ----
// reset cause/delay control constants: offsets, fields, resets, timing
// assumes 100 MHz core clock and a 32-bit avalon-mm word bus
`ifndef RCCDC_CFG_SVH
`define RCCDC_CFG_SVH
`define RCCDC_CLK_MHZ 100
`define RCCDC_OFS_CAUSE 4'h0
`define RCCDC_OFS_OSC 4'h4
`define RCCDC_OFS_STAT 4'h8
`define RCCDC_BIT_TRAP 15
`define RCCDC_BIT_ILLOP 14
`define RCCDC_BIT_VREG 8
`define RCCDC_BIT_PIN 7
`define RCCDC_BIT_SOFT 6
`define RCCDC_BIT_WDEN 5
`define RCCDC_BIT_WATCHDOG_TIMEOUT_FLAG 4
`define RCCDC_BIT_SLEEP 3
`define RCCDC_BIT_IDLE 2
`define RCCDC_BIT_BOR 1
`define RCCDC_BIT_POR 0
`define RCCDC_CAUSE_MASK 16'hc1ff
`define RCCDC_CAUSE_POR_VAL 16'h0003
`define RCCDC_POR_US 10
`define RCCDC_STARTUP_US 20
`define RCCDC_POWERUP_TIMER_MS 64
`define RCCDC_RST_US 20
`define RCCDC_LOCK_US 20
`define RCCDC_CLOCK_FAIL_MONITOR_US 100
`define RCCDC_OST_PERIODS 1024
`define RCCDC_US_CYC(t) ((t) * `RCCDC_CLK_MHZ)
`endif

// ---- pkg/rccdc_pkg.sv ----
// reset cause/delay control types
// assumes nothing beyond the constants header
package rccdc_pkg;
  typedef enum logic [2:0] {
    RCCDC_SRC_RC = 3'h0,
    RCCDC_SRC_RCPLL = 3'h1,
    RCCDC_SRC_XTAL = 3'h2,
    RCCDC_SRC_XTPLL = 3'h3,
    RCCDC_SRC_LOW_POWER_RC_SOURCE = 3'h4
  } rccdc_src_type;
  typedef enum logic [3:0] {
    RCCDC_ST_IDLE = 4'b0001,
    RCCDC_ST_HOLD = 4'b0010,
    RCCDC_ST_WAIT = 4'b0100,
    RCCDC_ST_RUN = 4'b1000
  } rccdc_state_type;
endpackage

// ---- src/rccdc_top.sv ----
// reset cause/delay control: cause flags, clock pick, release timing
// assumes one-cycle event pulses from detectors; avalon-mm slave
//
// How it works
// - trap conflict sets bit 15; cleared only by power-on or brown-out.
// - illegal operation reset sets bit 14; power-on or brown-out clears.
// - bits 13 to 9 read zero always.
// - bit 8 keeps regulator on in sleep; resets to zero.
// - pin reset sets bit 7; only power-on clears it.
// - reset instruction sets bit 6; power-on or brown-out clears.
// - bit 5 enables watchdog; fuse high forces it enabled.
// - watchdog timeout sets bit 4; power-save, power-on, brown-out clear.
// - sleep entry sets bit 3; power-on or brown-out clears.
// - idle entry sets bit 2; power-on or brown-out clears.
// - brown-out flag set by brown-out and power-on; resets to one.
// - power-on flag set by power-on; resets to one.
// - software writes flags freely; writes never start a reset.
// - switching on: por/bor use initial select, others keep current.
// - switching off: clock source always from configuration bits.
// - power-on release after power-on, start-up and internal delays.
// - start-up 20 us with regulator, 64 ms without; wake waits 20 us, only with regulator on.
// - brown-out holds start-up plus internal; others internal only.
// - crystal sources count 1024 oscillator periods, 11-bit counter.
// - pll sources add 20 us lock wait, after osc timer for crystal.
// - osc timer and lock wait run alongside the reset delay.
// - crystal or pll: monitor waits 100 us after release.
// - execution waits for released clock even after reset release.
`timescale 1ns/1ps
`include "rccdc_cfg.svh"
module rccdc_top #(
  parameter int POR_CYC = `RCCDC_US_CYC(`RCCDC_POR_US),
  parameter int STARTUP_CYC = `RCCDC_US_CYC(`RCCDC_STARTUP_US),
  parameter int POWERUP_TIMER_CYC = `RCCDC_US_CYC(`RCCDC_POWERUP_TIMER_MS * 1000),
  parameter int RST_CYC = `RCCDC_US_CYC(`RCCDC_RST_US),
  parameter int LOCK_CYC = `RCCDC_US_CYC(`RCCDC_LOCK_US),
  parameter int CLOCK_FAIL_MONITOR_CYC = `RCCDC_US_CYC(`RCCDC_CLOCK_FAIL_MONITOR_US),
  parameter int OST_PERIODS = `RCCDC_OST_PERIODS
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic por_evt_in,
  input wire logic bor_evt_in,
  input wire logic pin_rst_evt_in,
  input wire logic wdt_evt_in,
  input wire logic soft_rst_evt_in,
  input wire logic trap_evt_in,
  input wire logic illop_evt_in,
  input wire logic sleep_evt_in,
  input wire logic idle_evt_in,
  input wire logic wake_evt_in,
  input wire logic regulator_en_in,
  input wire logic watchdog_fuse_enable_in,
  input wire logic clk_switch_en_in,
  input wire logic [2:0] initial_osc_select_in,
  input wire logic osc_tick_in,
  output logic system_reset_line_out,
  output logic exec_enable_out,
  output logic clock_fail_monitor_en_out,
  output logic watchdog_enable_out,
  output logic regulator_sleep_keep_out,
  output logic [2:0] current_osc_select_out
);
  import rccdc_pkg::*;

  initial begin
    if (OST_PERIODS < 1 || OST_PERIODS > 1024 || POR_CYC < 1 || RST_CYC < 1 ||
        STARTUP_CYC < 1 || POWERUP_TIMER_CYC < 1 || LOCK_CYC < 1 || CLOCK_FAIL_MONITOR_CYC < 1) begin
      $error("rccdc_top: unsupported parameter value");
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_xtal(input logic [2:0] s);
    return (s == RCCDC_SRC_XTAL) || (s == RCCDC_SRC_XTPLL);
  endfunction
  function automatic logic is_pll(input logic [2:0] s);
    return (s == RCCDC_SRC_RCPLL) || (s == RCCDC_SRC_XTPLL);
  endfunction

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic [15:0] cause_q;
  logic [15:0] cause_d;
  logic [2:0] cur_osc_q;
  logic [2:0] cur_osc_d;
  logic rd_pend_q;
  logic ack_q;
  logic [31:0] rdata_q;
  wire req = (avs_read_in | avs_write_in) & ~ack_q;
  wire hit_cause = avs_address_in == `RCCDC_OFS_CAUSE;
  wire hit_osc = avs_address_in == `RCCDC_OFS_OSC;
  wire hit_stat = avs_address_in == `RCCDC_OFS_STAT;
  wire wr_cause = req & avs_write_in & hit_cause;
  wire wr_osc = req & avs_write_in & hit_osc & avs_byteenable_in[0];
  wire [15:0] be_mask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  wire [15:0] wr_val = (cause_q & ~be_mask) | (avs_writedata_in[15:0] & be_mask);

  // ----------------------------------------
  // cause flags
  // ----------------------------------------
  wire por_bor = por_evt_in | bor_evt_in;
  always_comb begin
    cause_d = cause_q;
    if (wr_cause) begin
      cause_d = wr_val;
    end
    if (por_bor) begin
      cause_d[`RCCDC_BIT_TRAP] = 1'b0;
      cause_d[`RCCDC_BIT_ILLOP] = 1'b0;
      cause_d[`RCCDC_BIT_SOFT] = 1'b0;
      cause_d[`RCCDC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
      cause_d[`RCCDC_BIT_SLEEP] = 1'b0;
      cause_d[`RCCDC_BIT_IDLE] = 1'b0;
    end
    if (por_evt_in) begin
      cause_d[`RCCDC_BIT_PIN] = 1'b0;
      cause_d[`RCCDC_BIT_VREG] = 1'b0;
      cause_d[`RCCDC_BIT_WDEN] = 1'b0;
      cause_d[`RCCDC_BIT_POR] = 1'b1;
    end
    if (sleep_evt_in | idle_evt_in) begin
      cause_d[`RCCDC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    end
    // hardware sets win over any clear
    if (trap_evt_in) cause_d[`RCCDC_BIT_TRAP] = 1'b1;
    if (illop_evt_in) cause_d[`RCCDC_BIT_ILLOP] = 1'b1;
    if (pin_rst_evt_in) cause_d[`RCCDC_BIT_PIN] = 1'b1;
    if (soft_rst_evt_in) cause_d[`RCCDC_BIT_SOFT] = 1'b1;
    if (wdt_evt_in) cause_d[`RCCDC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    if (sleep_evt_in) cause_d[`RCCDC_BIT_SLEEP] = 1'b1;
    if (idle_evt_in) cause_d[`RCCDC_BIT_IDLE] = 1'b1;
    if (por_bor) cause_d[`RCCDC_BIT_BOR] = 1'b1;
    cause_d = cause_d & `RCCDC_CAUSE_MASK;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cause_q <= `RCCDC_CAUSE_POR_VAL;
    end else begin
      cause_q <= cause_d;
    end
  end

  // ----------------------------------------
  // clock source pick
  // ----------------------------------------
  wire any_rst = por_bor | pin_rst_evt_in | wdt_evt_in | soft_rst_evt_in |
                 trap_evt_in | illop_evt_in;
  always_comb begin
    cur_osc_d = cur_osc_q;
    if (!clk_switch_en_in) begin
      cur_osc_d = initial_osc_select_in;
    end else if (por_bor) begin
      cur_osc_d = initial_osc_select_in;
    end else if (any_rst) begin
      cur_osc_d = cur_osc_q;
    end else if (wr_osc) begin
      cur_osc_d = avs_writedata_in[2:0];
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cur_osc_q <= 3'h0;
    end else begin
      cur_osc_q <= cur_osc_d;
    end
  end

  // ----------------------------------------
  // release timing
  // ----------------------------------------
  rccdc_state_type state_q;
  logic [31:0] rst_cnt_q;
  logic [31:0] clk_cnt_q;
  logic [10:0] ost_cnt_q;
  logic [31:0] clock_fail_monitor_cnt_q;
  logic ost_done_q;
  logic clk_ok_q;
  logic system_reset_line_q;
  wire [31:0] startup_cyc = regulator_en_in ? 32'(STARTUP_CYC) : 32'(POWERUP_TIMER_CYC);
  wire [31:0] rst_len = por_evt_in ? 32'(POR_CYC) + startup_cyc + 32'(RST_CYC) :
                        bor_evt_in ? startup_cyc + 32'(RST_CYC) : 32'(RST_CYC);
  wire [31:0] wake_len = 32'(STARTUP_CYC);
  wire need_clk = por_bor;
  wire rst_done = rst_cnt_q == 32'h0;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rst_cnt_q <= 32'(POR_CYC) + 32'(STARTUP_CYC) + 32'(RST_CYC);
      system_reset_line_q <= 1'b1;
    end else if (any_rst) begin
      rst_cnt_q <= rst_len;
      system_reset_line_q <= 1'b1;
    end else if (wake_evt_in && regulator_en_in) begin
      rst_cnt_q <= wake_len;
      system_reset_line_q <= 1'b0;
    end else if (!rst_done) begin
      rst_cnt_q <= rst_cnt_q - 32'h1;
    end else begin
      system_reset_line_q <= 1'b0;
    end
  end

  // osc timer and lock wait start with the reset, not after it
  wire [10:0] ost_top = 11'(OST_PERIODS);
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ost_cnt_q <= 11'h0;
      ost_done_q <= 1'b0;
      clk_cnt_q <= 32'h0;
      clk_ok_q <= 1'b0;
    end else if (need_clk) begin
      ost_cnt_q <= 11'h0;
      ost_done_q <= ~is_xtal(cur_osc_d);
      clk_cnt_q <= is_pll(cur_osc_d) ? 32'(LOCK_CYC) : 32'h0;
      clk_ok_q <= 1'b0;
    end else if (!ost_done_q) begin
      if (osc_tick_in) begin
        ost_cnt_q <= ost_cnt_q + 11'h1;
        ost_done_q <= (ost_cnt_q + 11'h1) == ost_top;
      end
    end else if (clk_cnt_q != 32'h0) begin
      clk_cnt_q <= clk_cnt_q - 32'h1;
    end else begin
      clk_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= RCCDC_ST_IDLE;
      clock_fail_monitor_cnt_q <= 32'h0;
    end else begin
      case (state_q)
        RCCDC_ST_IDLE: state_q <= RCCDC_ST_HOLD;
        RCCDC_ST_HOLD: begin
          if (!any_rst && rst_done) begin
            state_q <= RCCDC_ST_WAIT;
            clock_fail_monitor_cnt_q <= (is_xtal(cur_osc_q) | is_pll(cur_osc_q)) ?
                          32'(CLOCK_FAIL_MONITOR_CYC) : 32'h0;
          end
        end
        RCCDC_ST_WAIT: begin
          if (any_rst) begin
            state_q <= RCCDC_ST_HOLD;
          end else if (clock_fail_monitor_cnt_q != 32'h0) begin
            clock_fail_monitor_cnt_q <= clock_fail_monitor_cnt_q - 32'h1;
          end else begin
            state_q <= RCCDC_ST_RUN;
          end
        end
        RCCDC_ST_RUN: if (any_rst) state_q <= RCCDC_ST_HOLD;
        default: state_q <= RCCDC_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      system_reset_line_out <= 1'b1;
      exec_enable_out <= 1'b0;
      clock_fail_monitor_en_out <= 1'b0;
      watchdog_enable_out <= 1'b0;
      regulator_sleep_keep_out <= 1'b0;
      current_osc_select_out <= 3'h0;
    end else begin
      system_reset_line_out <= system_reset_line_q;
      exec_enable_out <= ~system_reset_line_q & clk_ok_q & rst_done;
      clock_fail_monitor_en_out <= state_q == RCCDC_ST_RUN;
      watchdog_enable_out <= cause_q[`RCCDC_BIT_WDEN] | watchdog_fuse_enable_in;
      regulator_sleep_keep_out <= cause_q[`RCCDC_BIT_VREG];
      current_osc_select_out <= cur_osc_q;
    end
  end

  // ----------------------------------------
  // bus answer: one wait cycle per access
  // ----------------------------------------
  wire [31:0] rd_mux = hit_cause ? {16'h0, cause_q} :
                       hit_osc ? {29'h0, cur_osc_q} :
                       hit_stat ? {28'h0, clk_ok_q, ost_done_q, exec_enable_out,
                                   system_reset_line_q} : 32'h0;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= req;
      rd_pend_q <= req & avs_read_in;
      if (req & avs_read_in) rdata_q <= rd_mux;
    end
  end
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = ~ack_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_trap_set;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    trap_evt_in |=> cause_q[`RCCDC_BIT_TRAP];
  endproperty
  a_trap_set: assert property (p_trap_set) else $error("trap flag not set");
  property p_unimpl;
    @(posedge core_clk_in) disable iff (sys_rst_in) cause_q[13:9] == 5'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused bits nonzero");
  property p_pin_bor;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    bor_evt_in && !por_evt_in && !wr_cause && cause_q[`RCCDC_BIT_PIN]
      |=> cause_q[`RCCDC_BIT_PIN];
  endproperty
  a_pin_bor: assert property (p_pin_bor) else $error("pin flag lost on brownout");
  property p_wdog;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    watchdog_fuse_enable_in |=> watchdog_enable_out;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog not forced");
  property p_watchdog_timeout_flag_clr;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    sleep_evt_in && !wdt_evt_in |=> !cause_q[`RCCDC_BIT_WATCHDOG_TIMEOUT_FLAG];
  endproperty
  a_watchdog_timeout_flag_clr: assert property (p_watchdog_timeout_flag_clr) else $error("timeout flag kept");
  property p_por_flags;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    por_evt_in |=> cause_q[`RCCDC_BIT_POR] && cause_q[`RCCDC_BIT_BOR];
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("por flags not set");
  sequence s_rst_hit;
    any_rst;
  endsequence
  property p_hold;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    s_rst_hit |=> system_reset_line_q ##1 system_reset_line_out;
  endproperty
  a_hold: assert property (p_hold) else $error("reset not held");
  property p_exec;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    exec_enable_out |-> $past(clk_ok_q) && !$past(system_reset_line_q);
  endproperty
  a_exec: assert property (p_exec) else $error("exec without clock");
  property p_osc_pick;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    por_bor |=> cur_osc_q == $past(initial_osc_select_in);
  endproperty
  a_osc_pick: assert property (p_osc_pick) else $error("wrong clock pick");
  property p_osc_keep;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    clk_switch_en_in && !por_bor && any_rst |=> cur_osc_q == $past(cur_osc_q);
  endproperty
  a_osc_keep: assert property (p_osc_keep) else $error("clock pick not kept");
  property p_wake_hold;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    wake_evt_in && regulator_en_in && !any_rst |=> ##1 !exec_enable_out;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake ran early");
endmodule

// ---- tb/tb_rccdc_top.sv ----
// testbench for the reset cause and delay control block
// assumes rccdc_top with shortened delay counts, driven over avalon-mm
`timescale 1ns/1ps
`include "rccdc_cfg.svh"
module tb_rccdc_top;
  import rccdc_pkg::*;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic por_ev = 1'b0, bor_ev = 1'b0, pin_ev = 1'b0, wdt_ev = 1'b0, soft_ev = 1'b0;
  logic trap_ev = 1'b0, illop_ev = 1'b0, sleep_ev = 1'b0, idle_ev = 1'b0, wake_ev = 1'b0;
  logic [3:0] be = 4'hf;
  logic regulator_en = 1'b1;
  logic fuse = 1'b0;
  logic switch_en = 1'b1;
  logic [2:0] init_osc = 3'h0;
  logic osc_tick = 1'b0;
  logic system_reset_line, exec_en, mon_en, wdog_en, reg_keep;
  logic [2:0] cur_osc;
  logic [31:0] q;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int t_rel = 0;
  int n;
  int idx[7] = '{2, 3, 4, 5, 6, 7, 8};
  int bitn[7] = '{7, 4, 6, 15, 14, 3, 2};
  int len[7] = '{20, 20, 20, 20, 20, 0, 0};
  rccdc_top #(.POR_CYC(10), .STARTUP_CYC(20), .POWERUP_TIMER_CYC(50), .RST_CYC(20), .LOCK_CYC(10),
    .CLOCK_FAIL_MONITOR_CYC(30), .OST_PERIODS(8)) DUT (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(be),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .por_evt_in(por_ev), .bor_evt_in(bor_ev), .pin_rst_evt_in(pin_ev), .wdt_evt_in(wdt_ev),
    .soft_rst_evt_in(soft_ev), .trap_evt_in(trap_ev), .illop_evt_in(illop_ev),
    .sleep_evt_in(sleep_ev), .idle_evt_in(idle_ev), .wake_evt_in(wake_ev),
    .regulator_en_in(regulator_en), .watchdog_fuse_enable_in(fuse),
    .clk_switch_en_in(switch_en), .initial_osc_select_in(init_osc), .osc_tick_in(osc_tick),
    .system_reset_line_out(system_reset_line), .exec_enable_out(exec_en),
    .clock_fail_monitor_en_out(mon_en), .watchdog_enable_out(wdog_en),
    .regulator_sleep_keep_out(reg_keep), .current_osc_select_out(cur_osc));
  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    if (wr) avs_write_in <= 1'b1;
    else avs_read_in <= 1'b1;
    @(posedge core_clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge core_clk_in);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // pulse one event, then time the system reset it causes (0 if none)
  task fire(input int i);
    int k;
    {wake_ev, idle_ev, sleep_ev, illop_ev, trap_ev, soft_ev, wdt_ev, pin_ev, bor_ev,
     por_ev} <= 10'h1 << i;
    @(posedge core_clk_in);
    {wake_ev, idle_ev, sleep_ev, illop_ev, trap_ev, soft_ev, wdt_ev, pin_ev, bor_ev,
     por_ev} <= 10'h0;
    n = 0;
    for (k = 0; k < 4 && system_reset_line !== 1'b1; k++) @(posedge core_clk_in);
    while (system_reset_line === 1'b1 && n < 300) begin
      @(posedge core_clk_in);
      n++;
    end
    t_rel = cyc;
  endtask
  task in_range(input int v, input int lo);
    chk(32'(v >= lo && v <= lo + 4), 32'h1);
  endtask
  task tick(input int cnt);
    repeat (cnt) begin
      osc_tick <= 1'b1;
      @(posedge core_clk_in);
      osc_tick <= 1'b0;
      @(posedge core_clk_in);
    end
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    rd_chk(`RCCDC_OFS_CAUSE, `RCCDC_CAUSE_POR_VAL);
    fire(0);
    in_range(n, 50);
    rd_chk(`RCCDC_OFS_CAUSE, 32'h0003);
    repeat (3) @(posedge core_clk_in);
    chk(exec_en, 1'b1);
    chk(mon_en, 1'b1);
    for (int k = 0; k < 7; k++) begin
      bus(1'b1, `RCCDC_OFS_CAUSE, 32'h0);
      fire(idx[k]);
      if (len[k] == 0) chk(n, 0);
      else in_range(n, len[k]);
      rd_chk(`RCCDC_OFS_CAUSE, 32'h1 << bitn[k]);
    end
    bus(1'b1, `RCCDC_OFS_CAUSE, 32'hffffffff);
    rd_chk(`RCCDC_OFS_CAUSE, 32'h0000c1ff);
    chk(system_reset_line, 1'b0);
    chk(reg_keep, 1'b1);
    chk(wdog_en, 1'b1);
    bus(1'b1, `RCCDC_OFS_CAUSE, 32'h0);
    rd_chk(`RCCDC_OFS_CAUSE, 32'h0);
    chk(reg_keep, 1'b0);
    chk(wdog_en, 1'b0);
    fuse <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    chk(wdog_en, 1'b1);
    fuse <= 1'b0;
    fire(3);
    fire(7);
    rd_chk(`RCCDC_OFS_CAUSE, 32'h0008);
    bus(1'b1, `RCCDC_OFS_CAUSE, 32'hc0dc);
    fire(1);
    in_range(n, 40);
    rd_chk(`RCCDC_OFS_CAUSE, 32'h0082);
    fire(0);
    rd_chk(`RCCDC_OFS_CAUSE, 32'h0003);
    bus(1'b1, 4'hc, 32'hffff);
    rd_chk(4'hc, 32'h0);
    rd_chk(`RCCDC_OFS_CAUSE, 32'h0003);
    be <= 4'h2;
    bus(1'b1, `RCCDC_OFS_CAUSE, 32'hffff);
    be <= 4'hf;
    rd_chk(`RCCDC_OFS_CAUSE, 32'h0000c103);
    // crystal source: execution waits for the oscillator timer
    init_osc <= RCCDC_SRC_XTAL;
    fire(0);
    chk(cur_osc, RCCDC_SRC_XTAL);
    tick(7);
    chk(exec_en, 1'b0);
    chk(mon_en, 1'b0);
    tick(1);
    repeat (3) @(posedge core_clk_in);
    chk(exec_en, 1'b1);
    rd_chk(`RCCDC_OFS_STAT, 32'h0000000e);
    for (int k = 0; k < 60 && mon_en !== 1'b1; k++) @(posedge core_clk_in);
    in_range(cyc - t_rel, 30);
    init_osc <= RCCDC_SRC_RCPLL;
    fire(2);
    in_range(n, 20);
    chk(cur_osc, RCCDC_SRC_XTAL);
    be <= 4'h1;
    bus(1'b1, `RCCDC_OFS_OSC, 32'(RCCDC_SRC_LOW_POWER_RC_SOURCE));
    be <= 4'hf;
    rd_chk(`RCCDC_OFS_OSC, 32'(RCCDC_SRC_LOW_POWER_RC_SOURCE));
    fire(3);
    chk(cur_osc, RCCDC_SRC_LOW_POWER_RC_SOURCE);
    fire(1);
    chk(cur_osc, RCCDC_SRC_RCPLL);
    repeat (3) @(posedge core_clk_in);
    chk(exec_en, 1'b1);
    switch_en <= 1'b0;
    init_osc <= RCCDC_SRC_LOW_POWER_RC_SOURCE;
    fire(4);
    chk(cur_osc, RCCDC_SRC_LOW_POWER_RC_SOURCE);
    fire(9);
    repeat (15) @(posedge core_clk_in);
    chk(exec_en, 1'b0);
    repeat (3) @(posedge core_clk_in);
    chk(exec_en, 1'b1);
    regulator_en <= 1'b0;
    fire(0);
    in_range(n, 80);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    errors++;
    test_done();
  end
endmodule
